/* src/sp0_pkg.sv */
// Register map, field positions, timing counts and carrier types of serial unit zero
package sp0_pkg;
  localparam int          ADDR_W    = 18;
  localparam logic [15:0] IDX_CTRL  = 16'h009B;
  localparam logic [15:0] IDX_BAUD  = 16'h00D8;
  localparam logic [15:0] IDX_MISC  = 16'hFFF1;
  localparam logic [15:0] IDX_BUF   = 16'h0099;
  localparam logic [15:0] IDX_RELL  = 16'h00AA;
  localparam logic [15:0] IDX_RELH  = 16'h00BA;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  BAUD_RST  = 8'h00;
  localparam logic [7:0]  MISC_RST  = 8'h00;
  localparam logic [7:0]  REL_RST   = 8'h00;
  localparam logic [7:0]  BAUD_MASK = 8'h80;
  localparam logic [7:0]  MISC_MASK = 8'h03;
  localparam logic [7:0]  RELH_MASK = 8'h03;
  localparam int          CTRL_MP   = 5;
  localparam int          CTRL_REN  = 4;
  localparam int          CTRL_TB8  = 3;
  localparam int          CTRL_RB8  = 2;
  localparam int          CTRL_TI   = 1;
  localparam int          CTRL_RI   = 0;
  localparam int          BAUD_BAUD_SOURCE_SELECT = 7;
  localparam int          MISC_LPBK = 1;
  localparam int          MISC_SEL  = 0;
  localparam logic [9:0]  GEN_TOP   = 10'h3FF;
  localparam logic [3:0]  OVS_LAST  = 4'hF;
  localparam logic [3:0]  SAMPLE_PH = 4'h7;
  localparam logic [3:0]  M0_LAST   = 4'hB;
  localparam logic [3:0]  M0_RISE   = 4'h6;
  localparam logic [3:0]  M0_BITS   = 4'h8;
  localparam logic [3:0]  FRAME8    = 4'hA;
  localparam logic [3:0]  FRAME9    = 4'hB;
  localparam logic [3:0]  M0_END    = 4'h7;
  localparam logic [3:0]  STOP8_IX  = 4'h9;
  localparam logic [3:0]  STOP9_IX  = 4'hA;

  typedef enum logic [1:0] {M_SHIFT, M_8BIT, M_9FIX, M_9VAR} sp0_mode_t;
  typedef enum logic {TX_IDLE, TX_RUN} sp0_tx_state_t;
  typedef enum logic {RX_IDLE, RX_RUN} sp0_rx_state_t;

  typedef struct packed {
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic              hready;
  } sp0_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } sp0_ahb_rsp_t;
endpackage

/* src/sp0_serial.sv */
// Serial unit zero with baud select, pin routing and AHB-Lite registers
`timescale 1ns/1ps
// What this block does
// - Baud select 0 takes timer 1 overflows, 1 takes the internal generator.
// - Unit select 1 routes unit one to the pins, 0 routes unit zero.
// - Loopback bit feeds transmit data straight back into receive.
// - Mode 0: RX carries data both ways, TX gives shift clock, LSB first.
// - Mode 0 bit time is twelve clocks whatever the baud source.
// - Mode 0 reception starts while receive-done is 0 and receive enable 1.
// - Modes 1 to 3: a start bit begins reception while receive enabled.
// - Mode 1 frame: start 0, eight data bits LSB first, stop 1.
// - Mode 1 receive: start resyncs, byte to buffer, stop to ninth flag.
// - Mode 1 rate follows the baud source select bit.
// - Mode 2 frame has eleven bits at 1/32 or 1/64 of clock.
// - Nine-bit modes send transmit ninth bit, store received ninth bit.
// - Mode 3 equals mode 2 but uses the selected baud source.
// - Hardware sets done flags at frame end; only software clears them.
// - Multiprocessor enable turns on address filtering in nine-bit modes.
// - One buffer: writes send a byte, reads return the last received byte.
// - In modes 1 to 3 with multiprocessor enable only ninth bit 1 frames raise receive-done.
// - Generator reload is ten bits: high register 1:0, low register 7:0.
module sp0_serial
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire sp0_pkg::sp0_ahb_req_t bus_in,
  output sp0_pkg::sp0_ahb_rsp_t     bus_out,
  input  wire logic                 timer1_ovf_in,
  input  wire logic                 smod_in,
  input  wire logic                 rx_pin_in,
  output logic                      rx_pin_out,
  output logic                      rx_pin_oe_n_out,
  output logic                      tx_out,
  input  wire logic                 alt_tx_in,
  output logic                      alt_rx_out
);
  import sp0_pkg::*;

  logic [7:0]    ctrl_q;
  logic [7:0]    ctrl_d;
  logic [7:0]    baud_q;
  logic [7:0]    misc_q;
  logic [7:0]    rell_q;
  logic [7:0]    relh_q;
  logic [7:0]    rbuf_q;
  logic [7:0]    rbuf_d;
  logic [7:0]    wdata8;
  logic [7:0]    rd_mux;
  logic          dwr_q;
  logic [15:0]   didx_q;
  logic [15:0]   aidx;
  logic [31:0]   hrdata_q;
  logic          ap;
  logic          ctrl_wr;
  logic          buf_wr;
  sp0_mode_t     mode;
  logic          m0;
  logic          baud_source_select;
  logic          lpbk;
  logic          sel;
  logic          mp;
  logic          ren;
  logic          ri;
  logic          pre_q;
  logic          half_q;
  logic          base;
  logic          tick;
  logic          gen_ovf;
  logic [9:0]    gen_q;
  logic [9:0]    reload;
  logic [3:0]    c12_q;
  sp0_tx_state_t tx_st_q;
  logic [10:0]   tsh_q;
  logic [3:0]    tbits_q;
  logic [3:0]    tph_q;
  logic          tx_start;
  logic          tx_step;
  logic          tx_done;
  logic          txd;
  sp0_rx_state_t rx_st_q;
  logic [7:0]    rsh_q;
  logic [3:0]    rbits_q;
  logic [3:0]    rph_q;
  logic          r9_q;
  logic          rx_s1_q;
  logic          rx_s2_q;
  logic          rx_prev_q;
  logic          rx0;
  logic          rx_go;
  logic          m0_rx_go;
  logic          rx_samp;
  logic          rx_last;
  logic          rx_end;
  logic          nine;
  logic          rx_take;
  logic          m0_busy;
  logic          sclk;
  logic          tx_q;
  logic          pin_q;
  logic          oe_n_q;
  logic          alt_rx_q;

  // Bus decode; zero wait states, so every transfer ends in its first data cycle
  assign ap      = bus_in.hsel && bus_in.htrans[1] && bus_in.hready;
  assign aidx    = bus_in.haddr[ADDR_W-1:2];
  assign wdata8  = bus_in.hwdata[7:0];
  assign ctrl_wr = dwr_q && (didx_q == IDX_CTRL);
  assign buf_wr  = dwr_q && (didx_q == IDX_BUF);
  assign rd_mux  = (aidx == IDX_CTRL) ? ctrl_q :
                   (aidx == IDX_BAUD) ? baud_q :
                   (aidx == IDX_MISC) ? misc_q :
                   (aidx == IDX_BUF)  ? rbuf_q :
                   (aidx == IDX_RELL) ? rell_q :
                   (aidx == IDX_RELH) ? relh_q : 8'h00;
  assign bus_out.hrdata    = hrdata_q;
  assign bus_out.hreadyout = 1'b1;
  assign bus_out.hresp     = 1'b0;

  assign mode = sp0_mode_t'(ctrl_q[7:6]);
  assign m0   = (mode == M_SHIFT);
  assign mp   = ctrl_q[CTRL_MP];
  assign ren  = ctrl_q[CTRL_REN];
  assign ri   = ctrl_q[CTRL_RI];
  assign baud_source_select = baud_q[BAUD_BAUD_SOURCE_SELECT];
  assign lpbk = misc_q[MISC_LPBK];
  assign sel  = misc_q[MISC_SEL];

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dwr_q    <= 1'b0;
      didx_q   <= 16'h0000;
      hrdata_q <= 32'h00000000;
    end
    else
    begin
      dwr_q  <= ap && bus_in.hwrite;
      didx_q <= aidx;
      if (ap && !bus_in.hwrite)
        hrdata_q <= {24'h000000, rd_mux};
    end
  end

  // hardware set wins over a software write in the same cycle
  always_comb
  begin
    ctrl_d = ctrl_wr ? wdata8 : ctrl_q;
    if (tx_done)
      ctrl_d[CTRL_TI] = 1'b1;
    if (rx_take)
    begin
      ctrl_d[CTRL_RI] = 1'b1;
      if (!m0)
        ctrl_d[CTRL_RB8] = nine;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      misc_q <= MISC_RST;
      rell_q <= REL_RST;
      relh_q <= REL_RST;
      rbuf_q <= 8'h00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      if (dwr_q && didx_q == IDX_BAUD)
        baud_q <= wdata8 & BAUD_MASK;
      if (dwr_q && didx_q == IDX_MISC)
        misc_q <= wdata8 & MISC_MASK;
      if (dwr_q && didx_q == IDX_RELL)
        rell_q <= wdata8;
      if (dwr_q && didx_q == IDX_RELH)
        relh_q <= wdata8 & RELH_MASK;
      if (rx_take)
        rbuf_q <= rbuf_d;
    end
  end

  assign reload  = {relh_q[1:0], rell_q};
  assign gen_ovf = pre_q && (gen_q == GEN_TOP);
  // source of the sixteen-times tick; share it, fixed
  assign base = (mode == M_9FIX) ? pre_q : (baud_source_select ? gen_ovf : timer1_ovf_in);
  // Halving unless doubled, so one divider covers all three rate sources
  assign tick = base && (smod_in || half_q);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pre_q  <= 1'b0;
      half_q <= 1'b0;
      gen_q  <= 10'h000;
      c12_q  <= 4'h0;
    end
    else
    begin
      pre_q <= !pre_q;
      if (pre_q)
        gen_q <= gen_ovf ? reload : gen_q + 10'h001;
      if (base)
        half_q <= !half_q;
      c12_q <= (tx_start || m0_rx_go || c12_q == M0_LAST) ? 4'h0 : c12_q + 4'h1;
    end
  end

  // Writes to the buffer while a frame is out are dropped, not queued
  assign tx_start = buf_wr && (tx_st_q == TX_IDLE);
  assign tx_step  = (tx_st_q == TX_RUN) &&
                    (m0 ? (c12_q == M0_LAST) : (tick && tph_q == OVS_LAST));
  assign tx_done  = tx_step && (tbits_q == 4'h1);
  assign txd      = (tx_st_q == TX_RUN) ? tsh_q[0] : 1'b1;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_st_q <= TX_IDLE;
      tsh_q   <= 11'h7FF;
      tbits_q <= 4'h0;
      tph_q   <= 4'h0;
    end
    else
    begin
      case (tx_st_q)
        TX_IDLE:
        begin
          if (tx_start)
          begin
            tx_st_q <= TX_RUN;
            tph_q   <= 4'h0;
            // framing; ninth bit from control, stop 1 in mode 1; start bit 0 except in mode 0
            tsh_q   <= m0 ? {3'b111, wdata8} :
                       {1'b1, (mode == M_8BIT) | ctrl_q[CTRL_TB8], wdata8, 1'b0};
            tbits_q <= m0 ? M0_BITS : ((mode == M_8BIT) ? FRAME8 : FRAME9);
          end
        end
        TX_RUN:
        begin
          if (tick)
            tph_q <= tph_q + 4'h1;
          if (tx_step)
          begin
            tsh_q   <= {1'b1, tsh_q[10:1]};
            tbits_q <= tbits_q - 4'h1;
          end
          if (tx_done)
            tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // loopback; deselected unit sees an idle line
  assign rx0 = sel ? 1'b1 : (lpbk ? txd : rx_s2_q);
  // start edge; gated by receive enable
  assign rx_go    = (rx_st_q == RX_IDLE) && !m0 && ren && rx_prev_q && !rx0;
  assign m0_rx_go = (rx_st_q == RX_IDLE) && m0 && ren && !ri &&
                    (tx_st_q == TX_IDLE) && !sel;
  assign rx_samp  = (rx_st_q == RX_RUN) &&
                    (m0 ? (c12_q == M0_RISE) : (tick && rph_q == SAMPLE_PH));
  assign rx_last  = m0 ? (rbits_q == M0_END) :
                    (rbits_q == ((mode == M_8BIT) ? STOP8_IX : STOP9_IX));
  assign rx_end   = rx_samp && rx_last;
  // stop bit stands in for the ninth bit
  assign nine     = (mode == M_8BIT) ? rx0 : r9_q;
  // address filter; data frames are dropped
  assign rx_take  = rx_end && !ri && (m0 || !mp || nine);
  assign rbuf_d   = m0 ? {rx0, rsh_q[7:1]} : rsh_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rx_st_q   <= RX_IDLE;
      rsh_q     <= 8'h00;
      rbits_q   <= 4'h0;
      rph_q     <= 4'h0;
      r9_q      <= 1'b0;
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_s1_q   <= rx_pin_in;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx0;
      case (rx_st_q)
        RX_IDLE:
        begin
          if (rx_go || m0_rx_go)
          begin
            rx_st_q <= RX_RUN;
            rph_q   <= 4'h0;
            rbits_q <= 4'h0;
          end
        end
        RX_RUN:
        begin
          if (tick)
            rph_q <= rph_q + 4'h1;
          if (rx_samp)
          begin
            // a high start sample is a glitch, back to hunting
            if ((!m0 && rbits_q == 4'h0 && rx0) || rx_last)
              rx_st_q <= RX_IDLE;
            if (m0 || (rbits_q != 4'h0 && rbits_q < STOP8_IX))
              rsh_q <= {rx0, rsh_q[7:1]};
            if (rbits_q == STOP8_IX)
              r9_q <= rx0;
            rbits_q <= rbits_q + 4'h1;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // shift clock low for the first half of each bit
  assign m0_busy = m0 && (tx_st_q == TX_RUN || rx_st_q == RX_RUN);
  assign sclk    = !m0_busy || (c12_q >= M0_RISE);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_q     <= 1'b1;
      pin_q    <= 1'b1;
      oe_n_q   <= 1'b1;
      alt_rx_q <= 1'b1;
    end
    else
    begin
      // pin routing; idle toward the unit left off
      tx_q     <= sel ? alt_tx_in : (m0 ? sclk : txd);
      pin_q    <= txd;
      oe_n_q   <= !(m0 && tx_st_q == TX_RUN && !sel);
      alt_rx_q <= sel ? rx_s2_q : 1'b1;
    end
  end

  assign tx_out          = tx_q;
  assign rx_pin_out      = pin_q;
  assign rx_pin_oe_n_out = oe_n_q;
  assign alt_rx_out      = alt_rx_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_m0_tx_go;
    tx_start && m0 && !sel;
  endsequence
  sequence s_frame_go;
    tx_start && !m0;
  endsequence

  property p_t1_src;
    (!baud_source_select && mode != M_9FIX && !timer1_ovf_in) |-> !tick;
  endproperty
  a_t1_src: assert property (p_t1_src)
    else $error("tick without timer 1 overflow");
  property p_alt_route;
    sel |=> (tx_out == $past(alt_tx_in));
  endproperty
  a_alt_route: assert property (p_alt_route)
    else $error("unit one not routed to TX");
  property p_loop;
    (lpbk && !sel && !m0 && tx_st_q == TX_RUN) |-> (rx0 == tsh_q[0]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback path broken");
  property p_m0_clk;
    s_m0_tx_go |=> ##1 (!tx_out)[*6] ##1 tx_out[*6];
  endproperty
  a_m0_clk: assert property (p_m0_clk)
    else $error("shift clock not six low six high");
  property p_m0_lsb;
    s_m0_tx_go |=> ##1 (!rx_pin_oe_n_out && rx_pin_out == $past(wdata8[0], 2));
  endproperty
  a_m0_lsb: assert property (p_m0_lsb)
    else $error("shift mode first bit not LSB on RX");
  property p_m0_rx;
    m0_rx_go |=> (rx_st_q == RX_RUN && c12_q == 4'h0);
  endproperty
  a_m0_rx: assert property (p_m0_rx)
    else $error("shift reception did not start");
  property p_no_ren;
    (rx_st_q == RX_IDLE && !ren) |=> (rx_st_q == RX_IDLE);
  endproperty
  a_no_ren: assert property (p_no_ren)
    else $error("reception started while disabled");
  property p_frame;
    s_frame_go |=> (txd == 1'b0 && tbits_q == ((mode == M_8BIT) ? FRAME8 : FRAME9));
  endproperty
  a_frame: assert property (p_frame)
    else $error("wrong start bit or frame length");
  property p_ti_set;
    tx_done |=> ctrl_q[CTRL_TI];
  endproperty
  a_ti_set: assert property (p_ti_set)
    else $error("transmit-done not set");
  property p_ri_hold;
    (ri && !ctrl_wr) |=> ri;
  endproperty
  a_ri_hold: assert property (p_ri_hold)
    else $error("receive-done cleared by hardware");
  property p_nine;
    (rx_take && !m0) |=> (ctrl_q[CTRL_RB8] == $past(nine));
  endproperty
  a_nine: assert property (p_nine)
    else $error("ninth bit not stored");
  property p_rd_buf;
    (ap && !bus_in.hwrite && aidx == IDX_BUF) |=> (bus_out.hrdata[7:0] == $past(rbuf_q));
  endproperty
  a_rd_buf: assert property (p_rd_buf)
    else $error("buffer read wrong");
  property p_mp_filter;
    (rx_end && mp && ctrl_q[7] && !r9_q) |-> !rx_take;
  endproperty
  a_mp_filter: assert property (p_mp_filter)
    else $error("data frame accepted under address filter");
  property p_reload;
    gen_ovf |=> (gen_q == $past(reload));
  endproperty
  a_reload: assert property (p_reload)
    else $error("generator reload wrong");
  property p_desel;
    (sel |-> rx0) and (!sel |=> alt_rx_out);
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselected unit sees RX");
endmodule

/* tb/sp0_host.sv */
// Serial host model on the far side of the TX and RX pins
`timescale 1ns/1ps
module sp0_host
(
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  int bit_clks = 32;

  initial line_out = 1'b1;

  task automatic set_line(input logic v);
    @(posedge clk_in);
    line_out <= v;
  endtask

  // start 0, LSB first, ninth bit as given, stop 1
  task automatic send(input logic [8:0] d, input int n);
    logic [10:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++)
      f[i + 1] = d[i];
    for (int i = 0; i < n + 2; i++)
    begin
      @(posedge clk_in);
      line_out <= f[i];
      repeat (bit_clks - 1) @(posedge clk_in);
    end
  endtask

  // mid-bit capture, start in bit 0, stop last
  task automatic recv(output logic [10:0] f, input int n);
    f = '1;
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < n + 2; i++)
    begin
      if (i > 0)
        repeat (bit_clks) @(posedge clk_in);
      f[i] = line_in;
    end
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for serial unit zero
`timescale 1ns/1ps
module tb_top;
  import sp0_pkg::*;
  logic         clk_in = 1'b0;
  logic         rst_in = 1'b1;
  sp0_ahb_req_t m      = '0;
  sp0_ahb_rsp_t s;
  logic         ovf    = 1'b0;
  logic [1:0]   oc     = 2'h0;
  logic         smod   = 1'b1;
  logic         alt_tx = 1'b1;
  logic         host_line;
  logic         rx_drv;
  logic         rx_oe_n;
  logic         tx;
  logic         alt_rx;
  wire          rx_wire;
  int           bad_count = 0;
  int           samples_checked = 0;

  always #5 clk_in = ~clk_in;
  always @(*) m.hready = s.hreadyout;
  // Timer overflow every fourth clock, slower than the generator on purpose
  always @(posedge clk_in)
  begin
    oc  <= oc + 2'h1;
    ovf <= (oc == 2'h0);
  end
  // Device wins the RX wire only while its enable is low
  assign rx_wire = rx_oe_n ? host_line : rx_drv;

  sp0_serial dut
  (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .bus_in          (m),
    .bus_out         (s),
    .timer1_ovf_in   (ovf),
    .smod_in         (smod),
    .rx_pin_in       (rx_wire),
    .rx_pin_out      (rx_drv),
    .rx_pin_oe_n_out (rx_oe_n),
    .tx_out          (tx),
    .alt_tx_in       (alt_tx),
    .alt_rx_out      (alt_rx)
  );

  sp0_host host
  (
    .clk_in   (clk_in),
    .line_in  (tx),
    .line_out (host_line)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [15:0] idx, input logic w, input logic [7:0] d,
                      output logic [31:0] r);
    @(posedge clk_in);
    m.hsel   <= 1'b1;
    m.haddr  <= {idx, 2'b00};
    m.htrans <= 2'b10;
    m.hwrite <= w;
    m.hsize  <= 3'b010;
    do @(posedge clk_in); while (s.hreadyout !== 1'b1);
    m.hsel   <= 1'b0;
    m.htrans <= 2'b00;
    m.hwdata <= {24'h000000, d};
    do @(posedge clk_in); while (s.hreadyout !== 1'b1);
    r = s.hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(idx, 1'b1, d, r);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] r);
    xfer(idx, 1'b0, 8'h00, r);
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] r;
    rd(idx, r);
    chk(r, {24'h000000, e});
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    int          k;
    k = 0;
    do
    begin
      rd(IDX_CTRL, r);
      k++;
    end while (r[b] !== v && k < 600);
    chk({31'h0, r[b]}, {31'h0, v});
  endtask

  task automatic t_regs;
    rchk(IDX_CTRL, CTRL_RST);
    rchk(IDX_BAUD, BAUD_RST);
    rchk(IDX_MISC, MISC_RST);
    wr(IDX_BAUD, 8'hFF);
    rchk(IDX_BAUD, BAUD_MASK);
    wr(IDX_MISC, 8'hFF);
    rchk(IDX_MISC, MISC_MASK);
    wr(IDX_MISC, 8'h00);
    wr(IDX_RELH, 8'hFF);
    rchk(IDX_RELH, 8'h03);
    wr(IDX_RELL, 8'hFF);
    rchk(IDX_RELL, 8'hFF);
    wr(16'h0123, 8'hFF);
    rchk(16'h0123, 8'h00);
    // Generator climbs once from zero before its reload rate holds
    repeat (2100) @(posedge clk_in);
  endtask

  task automatic tx_frame(input logic [7:0] c, input logic [7:0] d, input int n,
                          input logic [10:0] e);
    logic [10:0] f;
    wr(IDX_CTRL, c);
    fork
      host.recv(f, n);
      wr(IDX_BUF, d);
    join
    chk({21'h0, f}, {21'h0, e});
    poll(CTRL_TI, 1'b1);
    wr(IDX_CTRL, c);
    rchk(IDX_CTRL, c);
  endtask

  task automatic rx_frame(input logic [7:0] c, input logic [8:0] d, input int n,
                          input logic [7:0] eb, input logic eri);
    logic [31:0] r;
    wr(IDX_CTRL, c);
    host.send(d, n);
    repeat (40) @(posedge clk_in);
    rd(IDX_CTRL, r);
    chk({31'h0, r[CTRL_RI]}, {31'h0, eri});
    if (eri)
    begin
      chk({31'h0, r[CTRL_RB8]}, 32'h1);
      rchk(IDX_BUF, eb);
    end
    wr(IDX_CTRL, c);
  endtask

  task automatic t_m0(input logic [7:0] d);
    int n;
    wr(IDX_CTRL, 8'h00);
    fork
      wr(IDX_BUF, d);
      for (int i = 0; i < 8; i++)
      begin
        @(negedge tx);
        n = 0;
        do
        begin
          @(posedge clk_in);
          #1;
          n++;
        end while (tx === 1'b0);
        chk(n, 32'h6);
        chk({31'h0, rx_drv}, {31'h0, d[i]});
        chk({31'h0, rx_oe_n}, 32'h0);
      end
    join
    poll(CTRL_TI, 1'b1);
    host.set_line(1'b0);
    wr(IDX_CTRL, 8'h10);
    poll(CTRL_RI, 1'b1);
    rchk(IDX_BUF, 8'h00);
    wr(IDX_CTRL, 8'h00);
    host.set_line(1'b1);
  endtask

  task automatic t_pins;
    wr(IDX_MISC, 8'h02);
    wr(IDX_CTRL, 8'h50);
    wr(IDX_BUF, 8'h77);
    poll(CTRL_RI, 1'b1);
    rchk(IDX_BUF, 8'h77);
    wr(IDX_MISC, 8'h01);
    wr(IDX_CTRL, 8'h50);
    @(posedge clk_in);
    alt_tx <= 1'b0;
    host.set_line(1'b0);
    repeat (5) @(posedge clk_in);
    chk({31'h0, tx}, 32'h0);
    chk({31'h0, alt_rx}, 32'h0);
    wr(IDX_MISC, 8'h00);
    repeat (5) @(posedge clk_in);
    chk({31'h0, tx}, 32'h1);
    chk({31'h0, alt_rx}, 32'h1);
    host.set_line(1'b1);
    alt_tx <= 1'b1;
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Longest path is a dozen frames of under a thousand clocks each
  initial
  begin
    #500000;
    bad_count++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    tx_frame(8'h50, 8'hA5, 8, {2'b11, 8'hA5, 1'b0});
    rx_frame(8'h50, 9'h03C, 8, 8'h3C, 1'b1);
    tx_frame(8'h88, 8'h96, 9, {2'b11, 8'h96, 1'b0});
    // Undoubled fixed rate halves the bit rate
    smod <= 1'b0;
    host.bit_clks = 64;
    tx_frame(8'h88, 8'h3C, 9, {2'b11, 8'h3C, 1'b0});
    smod <= 1'b1;
    host.bit_clks = 32;
    tx_frame(8'hC0, 8'h69, 9, {2'b10, 8'h69, 1'b0});
    rx_frame(8'hF0, 9'h012, 9, 8'h00, 1'b0);
    rx_frame(8'hF0, 9'h134, 9, 8'h34, 1'b1);
    rx_frame(8'h40, 9'h055, 8, 8'h00, 1'b0);
    wr(IDX_BAUD, 8'h00);
    host.bit_clks = 64;
    tx_frame(8'h50, 8'h5A, 8, {2'b11, 8'h5A, 1'b0});
    wr(IDX_BAUD, 8'h80);
    host.bit_clks = 32;
    tx_frame(8'h50, 8'hC3, 8, {2'b11, 8'hC3, 1'b0});
    t_m0(8'hB4);
    t_pins();
    summarize();
  end
endmodule
